// ---- verilog/hbd_pkg.sv ----
// constants shared by the harmless burst dma engine
package hbd_pkg;

  // ------------------------------------------------------------
  // register byte addresses
  // ------------------------------------------------------------
  localparam logic [31:0] ADDR_TGT_B0 = 32'hf0833000;
  localparam logic [31:0] ADDR_TGT_B1 = 32'hf0833004;
  localparam logic [31:0] ADDR_TGT_B2 = 32'hf0833008;
  localparam logic [31:0] ADDR_TGT_B3 = 32'hf083300c;
  localparam logic [31:0] ADDR_TRIGGER = 32'hf0833010;
  localparam logic [31:0] ADDR_DONE_WR = 32'hf0833020;
  localparam logic [31:0] ADDR_STATUS = 32'hf082f020;
  localparam logic [31:0] ADDR_ERR_LOG = 32'hf082f040;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int DONE_WR_BIT = 0;
  localparam int DONE_RD_BIT = 7;
  localparam int BYTE_OFS_W = 2;
  localparam int ENGINE_LOG_BIT = 6;
  localparam int LOG_MASTERS = 7;
  localparam logic DONE_RST = 1'b0;
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [LOG_MASTERS-1:0] LOG_RST = 7'h00;
  localparam logic [1:0] BYTE_OFS_ZERO = 2'h0;

  // ------------------------------------------------------------
  // burst
  // ------------------------------------------------------------
  localparam int BURST_WRITES = 10;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_REQUEST,
    ST_WRITE,
    ST_FINISH
  } hbd_state_t;

endpackage

// ---- verilog/hbd_engine.sv ----
// harmless burst dma engine with wishbone register slave and error log
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps

module hbd_engine
#(
  parameter int BURST_LEN = hbd_pkg::BURST_WRITES
)
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [31:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatI,
  output logic [31:0] wbDatO,
  output logic wbAck,
  output logic hsbReq,
  input wire logic hsbGrant,
  output logic hsbValid,
  output logic [31:0] hsbAddr,
  output logic [31:0] hsbData,
  input wire logic hsbReady,
  input wire logic memBusErr,
  input wire logic [hbd_pkg::LOG_MASTERS-2:0] memOwner,
  output logic [hbd_pkg::LOG_MASTERS-1:0] masterEnable,
  output logic burstFinishedFlag
);
  import hbd_pkg::*;

  // ------------------------------------------------------------
  // elaboration check
  // ------------------------------------------------------------
  localparam int CNT_W = (BURST_LEN > 1) ? $clog2(BURST_LEN) : 1;
  localparam logic [CNT_W-1:0] LAST_BEAT = CNT_W'(BURST_LEN - 1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // the eight bit check counter below caps how long a burst may be
  if ((BURST_LEN < 1) || (BURST_LEN > 255))
  begin : g_bad_len
    $error("BURST_LEN must lie between one and 255");
  end

  // ------------------------------------------------------------
  // wishbone slave
  // ------------------------------------------------------------
  logic wbAck_q;
  logic [31:0] wbDatO_q;
  logic [31:0] wbDatO_d;
  wire request = wbCyc && wbStb;
  // a write lands on the edge where the master samples ack
  wire commit = request && wbAck_q && wbWe && wbSel[0];
  wire [7:0] wrByte = wbDatI[7:0];

  wire selB0 = (wbAdr == ADDR_TGT_B0);
  wire selB1 = (wbAdr == ADDR_TGT_B1);
  wire selB2 = (wbAdr == ADDR_TGT_B2);
  wire selB3 = (wbAdr == ADDR_TGT_B3);
  wire selTrig = (wbAdr == ADDR_TRIGGER);
  wire selDone = (wbAdr == ADDR_DONE_WR);
  wire selStat = (wbAdr == ADDR_STATUS);
  wire selLog = (wbAdr == ADDR_ERR_LOG);

  wire wrB0 = commit && selB0;
  wire wrB1 = commit && selB1;
  wire wrB2 = commit && selB2;
  wire wrB3 = commit && selB3;
  wire wrTrig = commit && selTrig;
  wire wrDone = commit && selDone;
  wire wrLog = commit && selLog;

  logic doneFlag_q;
  logic [LOG_MASTERS-1:0] errLog_q;

  // address and control registers are write-only and read back as zero
  always_comb
  begin
    wbDatO_d = '0;
    if (selStat)
    begin
      wbDatO_d[DONE_RD_BIT] = doneFlag_q;
    end
    else if (selLog)
    begin
      wbDatO_d[LOG_MASTERS-1:0] = errLog_q;
    end
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      wbAck_q <= 1'b0;
      wbDatO_q <= '0;
    end
    else
    begin
      wbAck_q <= request && !wbAck_q;
      wbDatO_q <= wbDatO_d;
    end
  end

  assign wbAck = wbAck_q;
  assign wbDatO = wbDatO_q;

  // ------------------------------------------------------------
  // target address bytes
  // ------------------------------------------------------------
  // no value is promised after reset; cleared only for clean simulation
  logic [7:0] tgtB0_q;
  logic [7:0] tgtB1_q;
  logic [7:0] tgtB2_q;
  logic [7:0] tgtB3_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tgtB0_q <= BYTE_RST;
      tgtB1_q <= BYTE_RST;
      tgtB2_q <= BYTE_RST;
      tgtB3_q <= BYTE_RST;
    end
    else
    begin
      if (wrB0)
        tgtB0_q <= wrByte;
      if (wrB1)
        tgtB1_q <= wrByte;
      if (wrB2)
        tgtB2_q <= wrByte;
      if (wrB3)
        tgtB3_q <= wrByte;
    end
  end

  wire [31:0] tgtAddr = {tgtB0_q, tgtB1_q, tgtB2_q, tgtB3_q};
  wire [31:0] wordAddr = {tgtAddr[31:BYTE_OFS_W], BYTE_OFS_ZERO};

  // ------------------------------------------------------------
  // burst sequencer
  // ------------------------------------------------------------
  hbd_state_t state_q;
  hbd_state_t state_d;
  logic [CNT_W-1:0] beat_q;
  logic [CNT_W-1:0] beat_d;
  logic [31:0] hsbAddr_q;

  wire engineEnabled = !errLog_q[ENGINE_LOG_BIT];
  // a trigger while busy or disabled is dropped, not queued
  wire startBurst = wrTrig && (state_q == ST_IDLE) && engineEnabled;
  wire beatDone = (state_q == ST_WRITE) && hsbReady;
  wire lastBeat = beatDone && (beat_q == LAST_BEAT);

  always_comb
  begin
    state_d = state_q;
    beat_d = beat_q;
    case (state_q)
      ST_IDLE:
      begin
        beat_d = CNT_ZERO;
        if (startBurst)
          state_d = ST_REQUEST;
      end
      ST_REQUEST:
      begin
        if (hsbGrant)
          state_d = ST_WRITE;
      end
      ST_WRITE:
      begin
        if (lastBeat)
          state_d = ST_FINISH;
        else if (beatDone)
          beat_d = beat_q + 1'b1;
      end
      ST_FINISH:
      begin
        state_d = ST_IDLE;
      end
      default:
      begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= ST_IDLE;
      beat_q <= CNT_ZERO;
      hsbAddr_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      beat_q <= beat_d;
      if (startBurst)
        hsbAddr_q <= wordAddr;
    end
  end

  // request stays high through the finish cycle, so the flag lands first
  assign hsbReq = (state_q != ST_IDLE);
  assign hsbValid = (state_q == ST_WRITE);
  assign hsbAddr = hsbAddr_q;
  assign hsbData = hsbAddr_q;

  // ------------------------------------------------------------
  // finished flag
  // ------------------------------------------------------------
  wire clearDone = wrDone && !wrByte[DONE_WR_BIT];

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      doneFlag_q <= DONE_RST;
    else if (lastBeat)
      doneFlag_q <= 1'b1;
    else if (clearDone)
      doneFlag_q <= 1'b0;
  end

  // plain status level only; there is deliberately no interrupt path
  assign burstFinishedFlag = doneFlag_q;

  // ------------------------------------------------------------
  // memory bus error log
  // ------------------------------------------------------------
  // the engine counts as memory-side owner only while hsbValid is high, in the write state, not while requesting or finishing
  wire [LOG_MASTERS-1:0] owners = {hsbValid, memOwner};
  wire [LOG_MASTERS-1:0] errHits = memBusErr ? owners : LOG_RST;
  wire [LOG_MASTERS-1:0] logSw = wrLog ? wrByte[LOG_MASTERS-1:0] : errLog_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      errLog_q <= LOG_RST;
    else
      errLog_q <= logSw | errHits;
  end

  assign masterEnable = ~errLog_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [7:0] beatsSeen_q;

  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
      beatsSeen_q <= '0;
    else if (state_q == ST_IDLE)
      beatsSeen_q <= '0;
    else if (beatDone)
      beatsSeen_q <= beatsSeen_q + 8'h01;
  end

  sequence s_last_beat;
    hsbValid && hsbReady && (beat_q == LAST_BEAT);
  endsequence

  sequence s_release;
    hsbReq ##1 !hsbReq;
  endsequence

  a_ten_writes: assert property (@(posedge clock) disable iff (sys_rst)
    s_release |-> $past(beatsSeen_q) == 8'(BURST_LEN))
    else $error("burst did not issue the set number of writes");

  a_addr_aligned: assert property (@(posedge clock) disable iff (sys_rst)
    hsbValid |-> (hsbAddr[1:0] == BYTE_OFS_ZERO) && $stable(hsbAddr))
    else $error("burst address not word aligned or moved");

  a_trigger_starts: assert property (@(posedge clock) disable iff (sys_rst)
    (wrTrig && !hsbReq && !errLog_q[ENGINE_LOG_BIT]) |=> hsbReq && !hsbValid)
    else $error("trigger write did not request the bus");

  a_grant_first: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(hsbValid) |-> $past(hsbGrant) && $past(hsbReq))
    else $error("write started without a grant");

  a_done_before_drop: assert property (@(posedge clock) disable iff (sys_rst)
    s_last_beat |=> doneFlag_q && hsbReq ##1 !hsbReq)
    else $error("flag not set before bus release");

  a_done_clear: assert property (@(posedge clock) disable iff (sys_rst)
    (wrDone && !wbDatI[0] && !lastBeat) |=> !doneFlag_q)
    else $error("writing zero did not clear the flag");

  a_done_keep: assert property (@(posedge clock) disable iff (sys_rst)
    (wrDone && wbDatI[0] && doneFlag_q) |=> doneFlag_q)
    else $error("writing one disturbed the flag");

  a_status_bit: assert property (@(posedge clock) disable iff (sys_rst)
    (request && !wbAck && !wbWe && (wbAdr == ADDR_STATUS))
      |=> wbAck && (wbDatO[7] == $past(doneFlag_q)) && (wbDatO[6:0] == 7'h00))
    else $error("status read did not show the flag in bit 7");

  a_log_sets: assert property (@(posedge clock) disable iff (sys_rst)
    memBusErr |=> ((errLog_q & $past(owners)) == $past(owners)))
    else $error("bus error owner not logged");

  a_slave_quiet: assert property (@(posedge clock) disable iff (sys_rst)
    (memBusErr && (owners == LOG_RST) && !wrLog) |=> $stable(errLog_q))
    else $error("bus error logged while only a slave");

  a_engine_off: assert property (@(posedge clock) disable iff (sys_rst)
    (errLog_q[ENGINE_LOG_BIT] && !hsbReq && !wrLog)
      |=> !hsbReq && !masterEnable[ENGINE_LOG_BIT])
    else $error("disabled engine started a burst");

  sequence s_granted;
    (state_q == ST_REQUEST) && hsbGrant;
  endsequence

  a_valid_after_grant: assert property (@(posedge clock) disable iff (sys_rst)
    s_granted |=> hsbValid && hsbReq)
    else $error("grant did not start the writes");

  a_wait_for_grant: assert property (@(posedge clock) disable iff (sys_rst)
    ((state_q == ST_REQUEST) && !hsbGrant) |=> !hsbValid)
    else $error("writes began before the grant");

  a_valid_holds_req: assert property (@(posedge clock) disable iff (sys_rst)
    hsbValid |-> hsbReq)
    else $error("write beat without bus request");

  a_beat_ceiling: assert property (@(posedge clock) disable iff (sys_rst)
    beatsSeen_q <= 8'(BURST_LEN))
    else $error("burst issued more writes than set");

  a_flag_on_last: assert property (@(posedge clock) disable iff (sys_rst)
    $rose(doneFlag_q) |-> $past(lastBeat))
    else $error("flag rose without a final write");

  a_flag_stays: assert property (@(posedge clock) disable iff (sys_rst)
    (doneFlag_q && !clearDone) |=> doneFlag_q)
    else $error("flag dropped without a clearing write");

  a_busy_trigger: assert property (@(posedge clock) disable iff (sys_rst)
    (wrTrig && hsbReq) |=> $stable(hsbAddr))
    else $error("trigger while busy disturbed the burst");

  a_ack_pulse: assert property (@(posedge clock) disable iff (sys_rst)
    wbAck |=> !wbAck)
    else $error("bus ack held longer than one cycle");

  a_log_replace: assert property (@(posedge clock) disable iff (sys_rst)
    (wrLog && !memBusErr) |=> (errLog_q == $past(logSw)))
    else $error("log write did not replace the logged bits");

endmodule

// ---- testbench/hbd_host_bus_model.sv ----
// host bus arbiter and memory model facing the burst engine
`timescale 1ns/1ps
module hbd_host_bus_model
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic hsbReq,
  input wire logic hsbValid,
  input wire logic [31:0] hsbAddr,
  input wire logic slow,
  output logic hsbGrant,
  output logic hsbReady,
  output int beats,
  output logic [31:0] lastAddr
);
  // ------------------------------------------------------------
  // arbiter and memory
  // ------------------------------------------------------------
  // grant lags the request by one cycle; slow mode raises ready only every other cycle, so every beat waits one cycle
  always_ff @(posedge clock or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hsbGrant <= 1'b0;
      hsbReady <= 1'b0;
      beats <= 0;
      lastAddr <= 32'h0;
    end
    else
    begin
      hsbGrant <= hsbReq;
      hsbReady <= hsbValid & (slow ? ~hsbReady : 1'b1);
      if (hsbValid && hsbReady)
      begin
        beats <= beats + 1;
        lastAddr <= hsbAddr;
      end
    end
  end
endmodule

// ---- testbench/hbd_engine_tb.sv ----
// self-checking bench for the burst engine
`timescale 1ns/1ps
`define CHK(n, e, g) begin testsRun++; if ((g) !== (e)) begin errCount++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module hbd_engine_tb;
  import hbd_pkg::*;
  logic clock, sys_rst, wbCyc, wbStb, wbWe, wbAck, hsbReq, hsbGrant, hsbValid, hsbReady;
  logic memBusErr, burstFinishedFlag, slow, flagWithReq;
  logic [31:0] wbAdr, wbDatI, wbDatO, hsbAddr, hsbData, lastAddr;
  logic [3:0] wbSel;
  logic [5:0] memOwner;
  logic [6:0] masterEnable;
  logic [7:0] rd;
  int beats, errCount, testsRun, cycles;
  hbd_engine DUT (.clock(clock), .sys_rst(sys_rst), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatI(wbDatI), .wbDatO(wbDatO),
    .wbAck(wbAck), .hsbReq(hsbReq), .hsbGrant(hsbGrant), .hsbValid(hsbValid),
    .hsbAddr(hsbAddr), .hsbData(hsbData), .hsbReady(hsbReady), .memBusErr(memBusErr),
    .memOwner(memOwner), .masterEnable(masterEnable), .burstFinishedFlag(burstFinishedFlag));
  hbd_host_bus_model partner (.clock(clock), .sys_rst(sys_rst), .hsbReq(hsbReq),
    .hsbValid(hsbValid), .hsbAddr(hsbAddr), .slow(slow), .hsbGrant(hsbGrant),
    .hsbReady(hsbReady), .beats(beats), .lastAddr(lastAddr));
  // ------------------------------------------------------------
  // clock, monitors, timeout
  // ------------------------------------------------------------
  initial
  begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (hsbReq && burstFinishedFlag)
      flagWithReq <= 1'b1;
    if (cycles == 20000)
    begin
      errCount++;
      final_report();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic wb(input logic we, input logic [31:0] a, input logic [7:0] d);
    @(posedge clock);
    {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, a, 4'h1, 24'h0, d};
    // only ack or the bench timeout ends this wait
    do
    begin
      @(posedge clock);
    end
    while (wbAck !== 1'b1);
    rd = wbDatO[7:0];
    {wbCyc, wbStb} <= 2'b00;
  endtask
  task automatic t_burst(input logic [31:0] a, input logic s);
    int b0, n;
    b0 = beats;
    slow <= s;
    flagWithReq <= 1'b0;
    wb(1, ADDR_TGT_B0, a[31:24]);
    wb(1, ADDR_TGT_B1, a[23:16]);
    wb(1, ADDR_TGT_B2, a[15:8]);
    wb(1, ADDR_TGT_B3, a[7:0]);
    wb(1, ADDR_TRIGGER, 8'h5a);
    // retrigger while busy must not lengthen the burst
    wb(1, ADDR_TRIGGER, 8'h00);
    n = 0;
    do
    begin
      wb(0, ADDR_STATUS, 8'h00);
      n++;
    end
    while (rd[7] !== 1'b1 && n < 100);
    `CHK("done", 1'b1, rd[7])
    `CHK("beats", b0 + BURST_WRITES, beats)
    `CHK("addr", {a[31:2], 2'h0}, lastAddr)
    `CHK("flagreq", 1'b1, flagWithReq)
    wb(1, ADDR_DONE_WR, 8'h01);
    wb(0, ADDR_STATUS, 8'h00);
    `CHK("keep", 1'b1, rd[7])
    wb(1, ADDR_DONE_WR, 8'hfe);
    wb(0, ADDR_STATUS, 8'h00);
    `CHK("clear", 1'b0, rd[7])
  endtask
  task automatic t_errlog(input logic [5:0] own, input logic [7:0] e);
    @(posedge clock);
    {memBusErr, memOwner} <= {1'b1, own};
    @(posedge clock);
    {memBusErr, memOwner} <= 7'h00;
    wb(0, ADDR_ERR_LOG, 8'h00);
    `CHK("log", e, rd)
    `CHK("enable", ~e[6:0], masterEnable)
    wb(1, ADDR_ERR_LOG, 8'h00);
    // the write lands on the ack edge; look once the log has settled
    @(posedge clock);
    `CHK("relog", 7'h7f, masterEnable)
  endtask
  task automatic t_engine_err();
    int b0, n;
    b0 = beats;
    // address bytes still hold the target of the burst before
    wb(1, ADDR_TRIGGER, 8'h33);
    do
    begin
      @(posedge clock);
    end
    while (hsbValid !== 1'b1);
    memBusErr <= 1'b1;
    @(posedge clock);
    memBusErr <= 1'b0;
    n = 0;
    do
    begin
      wb(0, ADDR_STATUS, 8'h00);
      n++;
    end
    while (rd[7] !== 1'b1 && n < 100);
    `CHK("engdone", 1'b1, rd[7])
    `CHK("engbeats", b0 + BURST_WRITES, beats)
    wb(0, ADDR_ERR_LOG, 8'h00);
    `CHK("englog", 8'h40, rd)
    `CHK("engoff", 7'h3f, masterEnable)
    wb(1, ADDR_DONE_WR, 8'h00);
    wb(1, ADDR_ERR_LOG, 8'h00);
    @(posedge clock);
    `CHK("engon", 7'h7f, masterEnable)
  endtask
  task automatic t_disabled();
    int b0;
    b0 = beats;
    wb(1, ADDR_ERR_LOG, 8'h40);
    wb(1, ADDR_TRIGGER, 8'h01);
    repeat (20) @(posedge clock);
    `CHK("blocked", b0, beats)
    `CHK("noreq", 1'b0, hsbReq)
    wb(1, ADDR_ERR_LOG, 8'h00);
  endtask
  task final_report();
    $display("comparisons %0d mismatches %0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    {sys_rst, wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} = {4'h8, 32'h0, 4'h0, 32'h0};
    {memBusErr, memOwner, slow, flagWithReq} = 9'h0;
    {errCount, testsRun, cycles} = {32'h0, 32'h0, 32'h0};
    repeat (10) @(posedge clock);
    sys_rst <= 1'b0;
    wb(0, ADDR_STATUS, 8'h00);
    `CHK("rstflag", DONE_RST, rd[7])
    `CHK("rstenable", 7'h7f, masterEnable)
    wb(0, 32'hf0833040, 8'h00);
    `CHK("unmapped", 8'h00, rd)
    t_burst(32'h1234567b, 1'b0);
    t_burst(32'habcdef02, 1'b1);
    t_errlog(6'h01, 8'h01);
    t_errlog(6'h20, 8'h20);
    t_errlog(6'h00, 8'h00);
    t_disabled();
    t_burst(32'h80000001, 1'b0);
    t_engine_err();
    final_report();
  end
endmodule
